// [verilog/mtdc_pkg.sv]
`default_nettype none
package mtdc_pkg;
	localparam int WORD_W    = 16;
	localparam int CTRL_AW   = 6;
	localparam int MEM_WORDS = 64;
	localparam int NUM_WORDS = 2;
	localparam int STR_WORDS = 10;
	localparam int DIGITS    = 8;
	localparam int STR_CHARS = 20;
	localparam int TYPE_MSB  = 15;
	localparam int TYPE_LSB  = 12;
	localparam int BCD_MSB   = 11;
	localparam int NIB_W     = 4;
	localparam int CH_W      = 8;
	localparam logic [CTRL_AW-1:0] OFS_DST = 6'h01;
	localparam logic [CTRL_AW-1:0] OFS_SRC = 6'h02;
	localparam logic [3:0] TYPE_STR     = 4'h0;
	localparam logic [3:0] TYPE_NUM     = 4'h1;
	localparam logic [3:0] TYPE_INVALID = 4'hF;
	localparam logic [3:0] DST_PAD      = 4'h0;
	localparam logic [3:0] NIB_NEG      = 4'hF;
	localparam logic [3:0] BCD_MAX      = 4'h9;
	localparam logic [3:0] CAP_ONE      = 4'h4;
	localparam logic [3:0] CAP_TWO      = 4'h8;
	localparam logic [3:0] STR_N_MAX    = 4'hA;
	localparam logic [3:0] STR_N_MIN    = 4'h1;
	localparam logic [9:0] STR_NUM_MAX  = 10'h0FF;
	localparam logic [9:0] NUM_NUM_MAX  = 10'h1FF;
	localparam logic [9:0] BCD_W2       = 10'h064;
	localparam logic [9:0] BCD_W1       = 10'h00A;
	localparam logic [15:0] LAST_RST    = 16'hFFFF;
	localparam logic [7:0] CH_ZERO  = 8'h30;
	localparam logic [7:0] CH_ALPHA = 8'h37;
	localparam logic [7:0] CH_MINUS = 8'h2D;
	localparam logic [7:0] CH_STAR  = 8'h2A;
	localparam logic [7:0] CH_SPACE = 8'h20;
	localparam logic [11:0] MEM_TOP  = 12'h100;
	localparam logic [11:0] REG_CMD  = 12'h100;
	localparam logic [11:0] REG_STAT = 12'h104;
	localparam logic [11:0] REG_BASE = 12'h108;
	localparam int CMD_DST_LSB = 0;
	localparam int CMD_SRC_LSB = 16;
	localparam int CMD_TYPE_LSB = 28;
	typedef enum logic [1:0] {
		MTDC_HEX  = 2'h0,
		MTDC_UDEC = 2'h1,
		MTDC_SDEC = 2'h2
	} mtdc_mode_t;

	function automatic logic bcd3_ok(input logic [11:0] b);
		return (b[11:8] <= BCD_MAX) && (b[7:4] <= BCD_MAX) && (b[3:0] <= BCD_MAX);
	endfunction

	function automatic logic [9:0] bcd3_val(input logic [11:0] b);
		return 10'(10'(b[11:8]) * BCD_W2 + 10'(b[7:4]) * BCD_W1 + 10'(b[3:0]));
	endfunction
endpackage
`default_nettype wire

// [verilog/mtdc_link_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface mtdc_link_if;
	logic                                req;
	logic [mtdc_pkg::CTRL_AW-1:0]        addr;
	logic                                ack;
	logic [mtdc_pkg::WORD_W-1:0]         rdata;
	modport term (output req, output addr, input ack, input rdata);
	modport ctrl (input req, input addr, output ack, output rdata);
endinterface
`default_nettype wire

// [verilog/mtdc_digit_fmt.sv]
`timescale 1ns/1ps
`default_nettype none
module mtdc_digit_fmt (
	input  wire logic                 blank_i,
	input  wire logic                 star_i,
	input  wire logic                 msd_i,
	input  wire mtdc_pkg::mtdc_mode_t mode_i,
	input  wire logic [3:0]           nib_i,
	output logic [7:0]                char_o
);
	logic [7:0] hex_c;

	// letters a..f pass through even in decimal modes, except an F in the leftmost digit
	assign hex_c = (nib_i > mtdc_pkg::BCD_MAX) ? 8'(mtdc_pkg::CH_ALPHA + 8'(nib_i))
		: 8'(mtdc_pkg::CH_ZERO + 8'(nib_i));

	always_comb begin
		char_o = hex_c;
		if (blank_i) begin
			char_o = mtdc_pkg::CH_SPACE;
		end else if (star_i) begin
			char_o = mtdc_pkg::CH_STAR;
		end else if (msd_i && nib_i == mtdc_pkg::NIB_NEG) begin
			unique case (mode_i)
				mtdc_pkg::MTDC_SDEC: char_o = mtdc_pkg::CH_MINUS;
				mtdc_pkg::MTDC_UDEC: char_o = mtdc_pkg::CH_ZERO;
				default:             char_o = hex_c;
			endcase
		end
	end
endmodule // mtdc_digit_fmt
`default_nettype wire

// [verilog/mtdc_terminal.sv]
// The AHB-Lite interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module mtdc_terminal #(
	parameter int NUM_TBL = 8,
	parameter int STR_TBL = 4
) (
	input  wire logic                 mclk_i,
	input  wire logic                 resetn_i,
	mtdc_link_if.term                 link,
	input  wire logic [5:0]           ctrl_base_i,
	input  wire logic [8:0]           num_sel_i,
	input  wire logic                 num_alloc_en_i,
	input  wire logic [5:0]           num_alloc_i,
	input  wire logic                 num_two_words_i,
	input  wire mtdc_pkg::mtdc_mode_t num_mode_i,
	input  wire logic [3:0]           num_width_i,
	input  wire logic [7:0]           str_sel_i,
	input  wire logic                 str_alloc_en_i,
	input  wire logic [5:0]           str_alloc_i,
	input  wire logic [3:0]           str_words_i,
	output logic [63:0]               num_text_o,
	output logic [159:0]              str_text_o,
	output logic                      copy_done_o,
	output logic                      copy_reject_o
);
	localparam int NIW = (NUM_TBL > 1) ? $clog2(NUM_TBL) : 1;
	localparam int SIW = (STR_TBL > 1) ? $clog2(STR_TBL) : 1;

	typedef enum logic [4:0] {
		S_DST = 5'b00001,
		S_SRC = 5'b00010,
		S_CHK = 5'b00100,
		S_NUM = 5'b01000,
		S_STR = 5'b10000
	} mtdc_poll_t;

	mtdc_poll_t  state_q, state_d;
	logic [3:0]  cnt_q, cnt_d;
	logic        req_q, req_d;
	logic [5:0]  addr_q, addr_d;
	logic [15:0] dst_q, dst_d, src_q, src_d;
	logic [15:0] last_dst_q, last_dst_d, last_src_q, last_src_d;
	logic        done_q, done_d, rej_q, rej_d;
	logic [15:0] num_tbl_q [NUM_TBL][mtdc_pkg::NUM_WORDS];
	logic [15:0] num_tbl_d [NUM_TBL][mtdc_pkg::NUM_WORDS];
	logic [15:0] str_tbl_q [STR_TBL][mtdc_pkg::STR_WORDS];
	logic [15:0] str_tbl_d [STR_TBL][mtdc_pkg::STR_WORDS];
	logic [63:0]  num_text_q, num_text_d;
	logic [159:0] str_text_q, str_text_d;

	logic       num_go, str_go, bcd_ok, changed, str_ok, num_ok;
	logic [3:0] ctype, str_n, cap;
	logic [9:0] dval, sval;
	logic [NIW-1:0] nidx;
	logic [SIW-1:0] sidx;
	logic [7:0] dig_c [mtdc_pkg::DIGITS];

	assign nidx   = num_sel_i[NIW-1:0];
	assign sidx   = str_sel_i[SIW-1:0];
	// only the tables on display are fetched from controller words
	assign num_go = num_alloc_en_i && (num_sel_i < 9'(NUM_TBL));
	assign str_go = str_alloc_en_i && (str_sel_i < 8'(STR_TBL));
	assign str_n  = (str_words_i == 4'h0) ? mtdc_pkg::STR_N_MIN
		: (str_words_i > mtdc_pkg::STR_N_MAX) ? mtdc_pkg::STR_N_MAX : str_words_i;
	assign cap    = num_two_words_i ? mtdc_pkg::CAP_TWO : mtdc_pkg::CAP_ONE;

	assign ctype   = src_q[mtdc_pkg::TYPE_MSB:mtdc_pkg::TYPE_LSB];
	assign dval    = mtdc_pkg::bcd3_val(dst_q[mtdc_pkg::BCD_MSB:0]);
	assign sval    = mtdc_pkg::bcd3_val(src_q[mtdc_pkg::BCD_MSB:0]);
	assign bcd_ok  = mtdc_pkg::bcd3_ok(dst_q[mtdc_pkg::BCD_MSB:0]) && mtdc_pkg::bcd3_ok(src_q[mtdc_pkg::BCD_MSB:0]);
	assign changed = (dst_q != last_dst_q) || (src_q != last_src_q);
	assign str_ok  = (ctype == mtdc_pkg::TYPE_STR) && bcd_ok
		&& dval <= mtdc_pkg::STR_NUM_MAX && sval <= mtdc_pkg::STR_NUM_MAX
		&& dval < 10'(STR_TBL) && sval < 10'(STR_TBL);
	assign num_ok  = (ctype == mtdc_pkg::TYPE_NUM) && bcd_ok
		&& dval <= mtdc_pkg::NUM_NUM_MAX && sval <= mtdc_pkg::NUM_NUM_MAX
		&& dval < 10'(NUM_TBL) && sval < 10'(NUM_TBL);

	// poll loop: copy setting words, then the displayed tables
	always_comb begin
		state_d    = state_q;
		cnt_d      = cnt_q;
		dst_d      = dst_q;
		src_d      = src_q;
		last_dst_d = last_dst_q;
		last_src_d = last_src_q;
		num_tbl_d  = num_tbl_q;
		str_tbl_d  = str_tbl_q;
		done_d     = 1'b0;
		rej_d      = 1'b0;
		unique case (state_q)
			S_DST: begin
				if (link.ack) begin
					dst_d   = link.rdata;
					state_d = S_SRC;
				end
			end
			S_SRC: begin
				if (link.ack) begin
					src_d   = link.rdata;
					state_d = S_CHK;
				end
			end
			S_CHK: begin
				// an unchanged setting never repeats a copy
				if (changed) begin
					last_dst_d = dst_q;
					last_src_d = src_q;
					if (str_ok) begin
						str_tbl_d[dval[SIW-1:0]] = str_tbl_q[sval[SIW-1:0]];
						done_d = 1'b1;
					end else if (num_ok) begin
						num_tbl_d[dval[NIW-1:0]] = num_tbl_q[sval[NIW-1:0]];
						done_d = 1'b1;
					end else if (ctype == mtdc_pkg::TYPE_STR || ctype == mtdc_pkg::TYPE_NUM) begin
						rej_d = 1'b1;
					end
				end
				cnt_d   = 4'h0;
				state_d = num_go ? S_NUM : (str_go ? S_STR : S_DST);
			end
			S_NUM: begin
				if (link.ack) begin
					// a table dropped from display mid-fetch must not take the word
					if (num_go) begin
						num_tbl_d[nidx][cnt_q[0]] = link.rdata;
					end
					if (cnt_q[0] == num_two_words_i) begin
						cnt_d   = 4'h0;
						state_d = str_go ? S_STR : S_DST;
					end else begin
						cnt_d = 4'(cnt_q + 4'h1);
					end
				end
			end
			S_STR: begin
				if (link.ack) begin
					if (str_go) begin
						str_tbl_d[sidx][cnt_q] = link.rdata;
					end
					if (cnt_q == 4'(str_n - 4'h1)) begin
						cnt_d   = 4'h0;
						state_d = S_DST;
					end else begin
						cnt_d = 4'(cnt_q + 4'h1);
					end
				end
			end
		endcase
		req_d = (state_d != S_CHK);
		unique case (state_d)
			S_DST:   addr_d = 6'(ctrl_base_i + mtdc_pkg::OFS_DST);
			S_SRC:   addr_d = 6'(ctrl_base_i + mtdc_pkg::OFS_SRC);
			S_NUM:   addr_d = 6'(num_alloc_i + 6'(cnt_d));
			S_STR:   addr_d = 6'(str_alloc_i + 6'(cnt_d));
			default: addr_d = addr_q;
		endcase
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q    <= S_DST;
			cnt_q      <= 4'h0;
			req_q      <= 1'b0;
			addr_q     <= 6'h00;
			dst_q      <= mtdc_pkg::LAST_RST;
			src_q      <= mtdc_pkg::LAST_RST;
			last_dst_q <= mtdc_pkg::LAST_RST;
			last_src_q <= mtdc_pkg::LAST_RST;
			done_q     <= 1'b0;
			rej_q      <= 1'b0;
			num_tbl_q  <= '{default: '0};
			str_tbl_q  <= '{default: '0};
		end else begin
			state_q    <= state_d;
			cnt_q      <= cnt_d;
			req_q      <= req_d;
			addr_q     <= addr_d;
			dst_q      <= dst_d;
			src_q      <= src_d;
			last_dst_q <= last_dst_d;
			last_src_q <= last_src_d;
			done_q     <= done_d;
			rej_q      <= rej_d;
			num_tbl_q  <= num_tbl_d;
			str_tbl_q  <= str_tbl_d;
		end
	end

	// numeral digits; digit 7 is leftmost
	for (genvar d = 0; d < mtdc_pkg::DIGITS; d++) begin : g_dig
		mtdc_digit_fmt u_fmt (
			.blank_i (4'(d) >= cap || !(num_sel_i < 9'(NUM_TBL))),
			.star_i  (num_width_i < cap),
			.msd_i   (4'(d) == 4'(cap - 4'h1)),
			.mode_i  (num_mode_i),
			.nib_i   (num_tbl_q[nidx][d / 4][(d % 4) * mtdc_pkg::NIB_W +: mtdc_pkg::NIB_W]),
			.char_o  (dig_c[d])
		);
	end

	always_comb begin
		num_text_d = '0;
		str_text_d = '0;
		for (int d = 0; d < mtdc_pkg::DIGITS; d++) begin
			num_text_d[d * mtdc_pkg::CH_W +: mtdc_pkg::CH_W] = dig_c[d];
		end
		for (int k = 0; k < mtdc_pkg::STR_CHARS; k++) begin
			if (k >= 2 * int'(str_n) || !(str_sel_i < 8'(STR_TBL))) begin
				str_text_d[(mtdc_pkg::STR_CHARS - 1 - k) * mtdc_pkg::CH_W +: mtdc_pkg::CH_W] = mtdc_pkg::CH_SPACE;
			end else begin
				// even character from the upper byte
				str_text_d[(mtdc_pkg::STR_CHARS - 1 - k) * mtdc_pkg::CH_W +: mtdc_pkg::CH_W] =
					str_tbl_q[sidx][k / 2][(1 - k % 2) * mtdc_pkg::CH_W +: mtdc_pkg::CH_W];
			end
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			num_text_q <= '0;
			str_text_q <= '0;
		end else begin
			num_text_q <= num_text_d;
			str_text_q <= str_text_d;
		end
	end

	assign link.req      = req_q;
	assign link.addr     = addr_q;
	assign num_text_o    = num_text_q;
	assign str_text_o    = str_text_q;
	assign copy_done_o   = done_q;
	assign copy_reject_o = rej_q;
endmodule // mtdc_terminal
`default_nettype wire

// [verilog/mtdc_controller.sv]
`timescale 1ns/1ps
`default_nettype none
module mtdc_controller (
	input  wire logic        mclk_i,
	input  wire logic        resetn_i,
	mtdc_link_if.ctrl        link,
	input  wire logic        hsel_i,
	input  wire logic [31:0] haddr_i,
	input  wire logic [1:0]  htrans_i,
	input  wire logic        hwrite_i,
	input  wire logic [2:0]  hsize_i,
	input  wire logic [31:0] hwdata_i,
	input  wire logic        hready_i,
	output logic [31:0]      hrdata_o,
	output logic             hreadyout_o,
	output logic             hresp_o
);
	typedef enum logic [3:0] {
		H_IDLE = 4'b0001,
		H_DST  = 4'b0010,
		H_INV  = 4'b0100,
		H_SRC  = 4'b1000
	} mtdc_seq_t;

	mtdc_seq_t   hst_q, hst_d;
	logic [15:0] mem_q [mtdc_pkg::MEM_WORDS];
	logic [15:0] mem_d [mtdc_pkg::MEM_WORDS];
	logic [31:0] cmd_q, cmd_d, hrdata_q, hrdata_d;
	logic [5:0]  base_q, base_d;
	logic        err_q, err_d, rep_q, rep_d, aw_q, aw_d;
	logic [11:0] aadr_q, aadr_d;
	logic        ack_q, ack_d, seen_q, seen_d;
	logic [15:0] rdat_q, rdat_d;
	logic [15:0] nsrc, ndst;
	logic [9:0]  dv, sv;
	logic [3:0]  nty;
	logic        cmd_ok;

	// fields of an incoming command word
	assign nty  = hwdata_i[mtdc_pkg::CMD_TYPE_LSB +: 4];
	assign ndst = {mtdc_pkg::DST_PAD, hwdata_i[mtdc_pkg::CMD_DST_LSB +: 12]};
	assign nsrc = {nty, hwdata_i[mtdc_pkg::CMD_SRC_LSB +: 12]};
	assign dv   = mtdc_pkg::bcd3_val(ndst[mtdc_pkg::BCD_MSB:0]);
	assign sv   = mtdc_pkg::bcd3_val(nsrc[mtdc_pkg::BCD_MSB:0]);
	assign cmd_ok = mtdc_pkg::bcd3_ok(ndst[mtdc_pkg::BCD_MSB:0]) && mtdc_pkg::bcd3_ok(nsrc[mtdc_pkg::BCD_MSB:0])
		&& ((nty == mtdc_pkg::TYPE_STR && dv <= mtdc_pkg::STR_NUM_MAX && sv <= mtdc_pkg::STR_NUM_MAX)
		|| (nty == mtdc_pkg::TYPE_NUM && dv <= mtdc_pkg::NUM_NUM_MAX && sv <= mtdc_pkg::NUM_NUM_MAX));

	always_comb begin
		mem_d    = mem_q;
		cmd_d    = cmd_q;
		base_d   = base_q;
		err_d    = err_q;
		rep_d    = rep_q;
		hst_d    = hst_q;
		aw_d     = 1'b0;
		aadr_d   = aadr_q;
		hrdata_d = hrdata_q;
		if (aw_q) begin
			if (aadr_q < mtdc_pkg::MEM_TOP) begin
				mem_d[aadr_q[mtdc_pkg::CTRL_AW+1:2]] = hwdata_i[15:0];
			end else if (aadr_q == mtdc_pkg::REG_BASE) begin
				base_d = hwdata_i[5:0];
			end else if (aadr_q == mtdc_pkg::REG_CMD && hst_q == H_IDLE) begin
				cmd_d = hwdata_i;
				err_d = !cmd_ok;
				// identical setting needs an invalid type first
				rep_d = (nsrc == mem_q[6'(base_q + mtdc_pkg::OFS_SRC)])
					&& (ndst == mem_q[6'(base_q + mtdc_pkg::OFS_DST)]);
				if (cmd_ok) begin
					hst_d = H_DST;
				end
			end
		end
		if (hsel_i && hready_i && htrans_i[1]) begin
			aw_d   = hwrite_i;
			aadr_d = {haddr_i[11:2], 2'b00};
			hrdata_d = '0;
			if (haddr_i[11:0] < mtdc_pkg::MEM_TOP) begin
				hrdata_d = {16'h0000, mem_q[haddr_i[mtdc_pkg::CTRL_AW+1:2]]};
			end else if ({haddr_i[11:2], 2'b00} == mtdc_pkg::REG_CMD) begin
				hrdata_d = cmd_q;
			end else if ({haddr_i[11:2], 2'b00} == mtdc_pkg::REG_STAT) begin
				hrdata_d = {30'h0, err_q, hst_q != H_IDLE};
			end else if ({haddr_i[11:2], 2'b00} == mtdc_pkg::REG_BASE) begin
				hrdata_d = {26'h0, base_q};
			end
		end
		// sequencer writes last so it wins over a bus write to the same word
		unique case (hst_q)
			H_IDLE: ;
			H_DST: begin
				mem_d[6'(base_q + mtdc_pkg::OFS_DST)] = {mtdc_pkg::DST_PAD, cmd_q[mtdc_pkg::CMD_DST_LSB +: 12]};
				hst_d = rep_q ? H_INV : H_SRC;
			end
			H_INV: begin
				mem_d[6'(base_q + mtdc_pkg::OFS_SRC)] = {mtdc_pkg::TYPE_INVALID, cmd_q[mtdc_pkg::CMD_SRC_LSB +: 12]};
				if (seen_q) begin
					hst_d = H_SRC;
				end
			end
			H_SRC: begin
				mem_d[6'(base_q + mtdc_pkg::OFS_SRC)] =
					{cmd_q[mtdc_pkg::CMD_TYPE_LSB +: 4], cmd_q[mtdc_pkg::CMD_SRC_LSB +: 12]};
				hst_d = H_IDLE;
			end
		endcase
	end

	// link answer; seen marks that the terminal has read the invalid type
	always_comb begin
		ack_d  = link.req && !ack_q;
		rdat_d = rdat_q;
		seen_d = 1'b0;
		if (ack_d) begin
			rdat_d = mem_q[link.addr];
			seen_d = (link.addr == 6'(base_q + mtdc_pkg::OFS_SRC))
				&& (mem_q[link.addr][mtdc_pkg::TYPE_MSB:mtdc_pkg::TYPE_LSB] == mtdc_pkg::TYPE_INVALID);
		end
	end

	always_ff @(posedge mclk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hst_q    <= H_IDLE;
			mem_q    <= '{default: '0};
			cmd_q    <= '0;
			base_q   <= 6'h00;
			err_q    <= 1'b0;
			rep_q    <= 1'b0;
			aw_q     <= 1'b0;
			aadr_q   <= 12'h000;
			hrdata_q <= '0;
			ack_q    <= 1'b0;
			rdat_q   <= 16'h0000;
			seen_q   <= 1'b0;
		end else begin
			hst_q    <= hst_d;
			mem_q    <= mem_d;
			cmd_q    <= cmd_d;
			base_q   <= base_d;
			err_q    <= err_d;
			rep_q    <= rep_d;
			aw_q     <= aw_d;
			aadr_q   <= aadr_d;
			hrdata_q <= hrdata_d;
			ack_q    <= ack_d;
			rdat_q   <= rdat_d;
			seen_q   <= seen_d;
		end
	end

	assign link.ack    = ack_q;
	assign link.rdata  = rdat_q;
	assign hrdata_o    = hrdata_q;
	assign hreadyout_o = 1'b1;
	assign hresp_o     = 1'b0;
endmodule // mtdc_controller
`default_nettype wire

// [test/mtdc_sva.sv]
`timescale 1ns/1ps
`default_nettype none
module mtdc_sva (
	input wire logic                         mclk_i,
	input wire logic                         resetn_i,
	input wire logic                         req_i,
	input wire logic [mtdc_pkg::CTRL_AW-1:0] addr_i,
	input wire logic                         ack_i,
	input wire logic [mtdc_pkg::WORD_W-1:0]  rdata_i
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!resetn_i);
	// a late answer lets the terminal miss a half-written copy setting
	a_ack_next: assert property (req_i && !ack_i |=> ack_i)
		else $error("request not answered next cycle");
	a_ack_pulse: assert property (ack_i |=> !ack_i)
		else $error("ack longer than one cycle");
	a_ack_cause: assert property (!req_i |=> !ack_i)
		else $error("ack without request");
	a_addr_hold: assert property (req_i && !ack_i |=> req_i && $stable(addr_i))
		else $error("request changed before ack");
	a_data_hold: assert property (!ack_i |-> $stable(rdata_i))
		else $error("read data moved without ack");
	a_ack_in_req: assert property (ack_i |-> req_i)
		else $error("ack outside request");
	a_check_gap: assert property ($fell(req_i) |=> req_i)
		else $error("check gap not one cycle");
	a_loop_bound: assert property ($rose(req_i) |-> ##[1:64] !req_i)
		else $error("setting not checked within loop");
	c_read: cover property (ack_i);
	c_check: cover property ($fell(req_i));
	c_burst: cover property (ack_i ##2 ack_i);
endmodule // mtdc_sva
`default_nettype wire

// [test/tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	logic                 mclk_i;
	logic                 resetn_i;
	logic                 hsel;
	logic [31:0]          haddr;
	logic [1:0]           htrans;
	logic                 hwrite;
	logic [31:0]          hwdata;
	logic [31:0]          hrdata;
	logic                 hready;
	logic                 hresp;
	logic [5:0]           ctrl_base;
	logic [8:0]           num_sel;
	logic                 num_en;
	logic                 num_two;
	mtdc_pkg::mtdc_mode_t num_mode;
	logic [3:0]           num_width;
	logic [7:0]           str_sel;
	logic                 str_en;
	logic [3:0]           str_words;
	logic [63:0]          num_text;
	logic [159:0]         str_text;
	logic [159:0]         str_exp;
	logic                 done;
	logic                 rej;
	int                   n_errors;
	int                   comparisons;
	int                   n_done;
	int                   n_rej;

	mtdc_link_if lk();
	mtdc_terminal #(.NUM_TBL(8), .STR_TBL(4)) mtdc_terminal_i (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .link(lk.term), .ctrl_base_i(ctrl_base),
		.num_sel_i(num_sel), .num_alloc_en_i(num_en), .num_alloc_i(6'h04), .num_two_words_i(num_two),
		.num_mode_i(num_mode), .num_width_i(num_width), .str_sel_i(str_sel), .str_alloc_en_i(str_en),
		.str_alloc_i(6'h08), .str_words_i(str_words), .num_text_o(num_text), .str_text_o(str_text),
		.copy_done_o(done), .copy_reject_o(rej));
	mtdc_controller mtdc_controller_i (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .link(lk.ctrl), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready),
		.hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp));
	mtdc_sva mtdc_sva_i (
		.mclk_i(mclk_i), .resetn_i(resetn_i), .req_i(lk.req), .addr_i(lk.addr), .ack_i(lk.ack),
		.rdata_i(lk.rdata));

	always #10 mclk_i = ~mclk_i;

	always @(posedge mclk_i) begin
		if (done === 1'b1)
			n_done++;
		if (rej === 1'b1)
			n_rej++;
	end

	task automatic chk(input logic [159:0] s, input logic [159:0] e);
		comparisons++;
		if (s !== e) begin
			n_errors++;
			$display("wrong value at %0t: saw %h expected %h", $time, s, e);
		end
	endtask

	task automatic results();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
		@(posedge mclk_i);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {20'h00000, a};
		do @(posedge mclk_i); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk_i); while (hready !== 1'b1);
		r = hrdata;
		chk(hresp, 1'b0);
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h00000000, r);
	endtask

	// three check gaps guarantee one whole fetch loop after the last write
	task automatic wait_loop();
		int i;
		repeat (3) begin
			i = 0;
			@(posedge mclk_i);
			while (lk.req !== 1'b0 && i < 200) begin
				@(posedge mclk_i);
				i++;
			end
			// a stalled fetch loop counts as a mismatch
			chk(i < 200, 1'b1);
			@(posedge mclk_i);
		end
	endtask

	task automatic wait_idle();
		logic [31:0] r;
		int i;
		i = 0;
		r = 32'h00000001;
		while (r[0] !== 1'b0 && i < 100) begin
			rd(12'h104, r);
			i++;
		end
		chk(r[1:0], 2'h0);
	endtask

	task automatic t_regs();
		logic [31:0] r;
		rd(12'h108, r);
		chk(r, 32'h00000000);
		rd(12'h100, r);
		chk(r, 32'h00000000);
		wr(12'h108, 32'h00000020);
		rd(12'h108, r);
		chk(r, 32'h00000020);
		wr(12'h200, 32'h00001234);
		rd(12'h200, r);
		chk(r, 32'h00000000);
		// string table 256 is out of range: refused and flagged, not started
		wr(12'h100, 32'h00000256);
		rd(12'h104, r);
		chk(r, 32'h00000002);
		$display("test regs done");
	endtask

	task automatic num_case(input logic t, input mtdc_pkg::mtdc_mode_t m, input logic [3:0] wd,
		input logic [15:0] w1, input logic [15:0] w0, input logic [63:0] e);
		@(posedge mclk_i);
		num_two <= t;
		num_mode <= m;
		num_width <= wd;
		wr(12'h010, {16'h0000, w0});
		wr(12'h014, {16'h0000, w1});
		wait_loop();
		chk(num_text, e);
	endtask

	task automatic t_numeral();
		num_case(1'b0, mtdc_pkg::MTDC_SDEC, 4'h4, 16'h9999, 16'hF123, 64'h202020202D313233);
		num_case(1'b0, mtdc_pkg::MTDC_HEX, 4'h3, 16'h9999, 16'h1234, 64'h202020202A2A2A2A);
		num_case(1'b1, mtdc_pkg::MTDC_SDEC, 4'h8, 16'h1234, 16'h5678, 64'h3132333435363738);
		num_case(1'b1, mtdc_pkg::MTDC_SDEC, 4'h8, 16'hF012, 16'h3B56, 64'h2D30313233423536);
		num_case(1'b1, mtdc_pkg::MTDC_UDEC, 4'h8, 16'hF012, 16'h3B56, 64'h3030313233423536);
		num_case(1'b1, mtdc_pkg::MTDC_HEX, 4'h8, 16'hF012, 16'h3B56, 64'h4630313233423536);
		num_case(1'b1, mtdc_pkg::MTDC_HEX, 4'h7, 16'hF012, 16'h3B56, {8{8'h2A}});
		$display("test numeral done");
	endtask

	task automatic t_string();
		for (int k = 0; k < 10; k++) begin
			wr(12'h020 + 12'(4 * k), {16'h0000, 8'h41 + 8'(2 * k), 8'h42 + 8'(2 * k)});
			str_exp[159 - 16 * k -: 16] = {8'h41 + 8'(2 * k), 8'h42 + 8'(2 * k)};
		end
		wait_loop();
		chk(str_text, str_exp);
		@(posedge mclk_i);
		str_words <= 4'h3;
		str_exp[111:0] = {14{8'h20}};
		wait_loop();
		chk(str_text, str_exp);
		$display("test string done");
	endtask

	task automatic t_copy();
		logic [31:0] r;
		int d;
		d = n_done;
		// tables 1 and 3 share width and display method
		wr(12'h100, 32'h10010003);
		wait_idle();
		wait_loop();
		chk(n_done, d + 1);
		rd(12'h084, r);
		chk(r, 32'h00000003);
		rd(12'h088, r);
		chk(r, 32'h00001001);
		@(posedge mclk_i);
		num_sel <= 9'h003;
		num_en <= 1'b0;
		num_width <= 4'h8;
		wait_loop();
		chk(num_text, 64'h4630313233423536);
		wr(12'h100, 32'h10010003);
		wait_idle();
		wait_loop();
		chk(n_done, d + 2);
		wr(12'h088, 32'h00002001);
		wait_loop();
		chk(n_done, d + 2);
		wr(12'h088, 32'h00001001);
		wait_loop();
		chk(n_done, d + 3);
		// park on an invalid type first so the half-written setting stays silent
		d = n_rej;
		wr(12'h088, 32'h0000F002);
		wr(12'h084, 32'h00000256);
		wr(12'h088, 32'h00000002);
		wait_loop();
		chk(n_rej, d + 1);
		d = n_done;
		wr(12'h084, 32'h00000003);
		wr(12'h088, 32'h00000002);
		@(posedge mclk_i);
		str_sel <= 8'h03;
		str_en <= 1'b0;
		wait_loop();
		chk(n_done, d + 1);
		chk(str_text, str_exp);
		$display("test copy done");
	endtask

	initial begin
		#400000;
		n_errors++;
		$display("watchdog expired");
		results();
	end

	initial begin
		mclk_i = 1'b0;
		resetn_i = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		ctrl_base = 6'h20;
		num_sel = 9'h001;
		num_en = 1'b1;
		num_two = 1'b1;
		num_mode = mtdc_pkg::MTDC_HEX;
		num_width = 4'h8;
		str_sel = 8'h02;
		str_en = 1'b1;
		str_words = 4'hF;
		str_exp = '0;
		n_errors = 0;
		comparisons = 0;
		n_done = 0;
		n_rej = 0;
		repeat (20) @(posedge mclk_i);
		resetn_i <= 1'b1;
		t_regs();
		t_numeral();
		t_string();
		t_copy();
		results();
	end
endmodule // tb_top
`default_nettype wire
